// File: src/suspend_ctrl.v
// Program/erase sequencer with suspend and resume control
`timescale 1ns/1ps
`default_nettype none
`include "suspend_map.vh"
module suspend_ctrl #(
    parameter PGM_CYC = 50000,
    parameter SSE_CYC = 100000,
    parameter SE_CYC = 200000,
    parameter BE_CYC = 400000
) (
    input wire mclk_in,
    input wire reset_in,
    input wire sclk_in,
    input wire cs_n_in,
    input wire mosi_in,
    output reg cmd_valid_out,
    output reg [7:0] cmd_byte_out,
    output reg cmd_reject_out,
    output reg busy_out,
    output reg suspended_out,
    output reg [2:0] op_kind_out,
    output reg done_out
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam [1:0] ST_IDLE = 2'b00;
localparam [1:0] ST_RUN = 2'b01;
localparam [1:0] ST_SUSP_WAIT = 2'b10;
localparam [1:0] ST_SUSP = 2'b11;
localparam [11:0] PGM_LAT = `PGM_SUSP_CYC;
localparam [11:0] SSE_LAT = `SSE_SUSP_CYC;
localparam [11:0] ERS_LAT = `ERS_SUSP_CYC;

reg [1:0] state_r;
reg [1:0] state_nxt;
reg [2:0] kind_r;
reg [2:0] kind_nxt;
reg [31:0] remain_r;
reg [31:0] remain_nxt;
reg [11:0] lat_r;
reg [11:0] lat_nxt;
reg acc_nxt;
reg rej_nxt;
reg done_nxt;

wire op_valid;
wire [7:0] op_byte;

cmd_shift_in u_rx (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .mosi_in(mosi_in),
    .op_valid_out(op_valid),
    .op_byte_out(op_byte)
);

// ----------------------------------------------------------------
// Decoding
// ----------------------------------------------------------------
function [2:0] start_kind;
    input [7:0] op;
    begin
        if (op == `OP_PROGRAM)
            start_kind = `KIND_PGM;
        else if (op == `OP_SUBSECTOR_ERASE)
            start_kind = `KIND_SSE;
        else if (op == `OP_SECTOR_ERASE)
            start_kind = `KIND_SE;
        else if (op == `OP_BULK_ERASE_A || op == `OP_BULK_ERASE_B)
            start_kind = `KIND_BE;
        else
            start_kind = `KIND_NONE;
    end
endfunction

function is_read;
    input [7:0] op;
    begin
        is_read = (op == `OP_READ) || (op == `OP_FAST_READ) ||
                  (op == `OP_READ_STATUS);
    end
endfunction

function is_excluded;
    input [7:0] op;
    begin
        is_excluded = (op == `OP_SUBSECTOR_ERASE) ||
                      (op == `OP_SECTOR_ERASE) ||
                      (op == `OP_BULK_ERASE_A) ||
                      (op == `OP_BULK_ERASE_B) ||
                      (op == `OP_WRITE_STATUS) ||
                      (op == `OP_WRITE_NVCFG) ||
                      (op == `OP_PROGRAM_OTP);
    end
endfunction

function [31:0] op_length;
    input [2:0] k;
    begin
        case (k)
            `KIND_PGM: op_length = PGM_CYC;
            `KIND_SSE: op_length = SSE_CYC;
            `KIND_SE: op_length = SE_CYC;
            default: op_length = BE_CYC;
        endcase
    end
endfunction

function [11:0] susp_latency;
    input [2:0] k;
    begin
        case (k)
            `KIND_PGM: susp_latency = PGM_LAT;
            `KIND_SSE: susp_latency = SSE_LAT;
            default: susp_latency = ERS_LAT;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------
always @* begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    remain_nxt = remain_r;
    lat_nxt = lat_r;
    acc_nxt = 1'b0;
    rej_nxt = 1'b0;
    done_nxt = 1'b0;
    case (state_r)
        ST_IDLE: begin
            if (op_valid) begin
                acc_nxt = 1'b1;
                if (start_kind(op_byte) != `KIND_NONE) begin
                    kind_nxt = start_kind(op_byte);
                    remain_nxt = op_length(start_kind(op_byte));
                    state_nxt = ST_RUN;
                end
            end
        end
        ST_RUN: begin
            if (remain_r <= 32'h1) begin
                remain_nxt = 32'h0;
                kind_nxt = `KIND_NONE;
                done_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end else begin
                remain_nxt = remain_r - 32'h1;
            end
            if (op_valid) begin
                if (op_byte == `OP_SUSPEND && remain_r > 32'h1) begin
                    // Accepted at any time after start or resume while more than one cycle remains
                    acc_nxt = 1'b1;
                    lat_nxt = susp_latency(kind_r);
                    state_nxt = ST_SUSP_WAIT;
                end else if (op_byte == `OP_READ_STATUS) begin
                    acc_nxt = 1'b1;
                end else begin
                    rej_nxt = 1'b1;
                end
            end
        end
        ST_SUSP_WAIT: begin
            if (remain_r <= 32'h1) begin
                remain_nxt = 32'h0;
                kind_nxt = `KIND_NONE;
                done_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end else begin
                remain_nxt = remain_r - 32'h1;
                if (lat_r <= 12'h1) begin
                    state_nxt = ST_SUSP;
                end else begin
                    lat_nxt = lat_r - 12'h1;
                end
            end
            if (op_valid) begin
                if (op_byte == `OP_READ_STATUS)
                    acc_nxt = 1'b1;
                else
                    rej_nxt = 1'b1;
            end
        end
        default: begin
            // Remaining count is held untouched while suspended
            if (op_valid) begin
                if (op_byte == `OP_RESUME) begin
                    acc_nxt = 1'b1;
                    state_nxt = ST_RUN;
                end else if (op_byte == `OP_SUSPEND) begin
                    rej_nxt = 1'b1;
                end else if (kind_r == `KIND_PGM) begin
                    if (is_read(op_byte))
                        acc_nxt = 1'b1;
                    else
                        rej_nxt = 1'b1;
                end else if (is_excluded(op_byte)) begin
                    rej_nxt = 1'b1;
                end else begin
                    acc_nxt = 1'b1;
                end
            end
        end
    endcase
end

// ----------------------------------------------------------------
// Registers and outputs
// ----------------------------------------------------------------
always @(posedge mclk_in) begin
    if (reset_in) begin
        state_r <= ST_IDLE;
        kind_r <= `KIND_NONE;
        remain_r <= 32'h0;
        lat_r <= 12'h000;
        cmd_valid_out <= 1'b0;
        cmd_byte_out <= 8'h00;
        cmd_reject_out <= 1'b0;
        busy_out <= 1'b0;
        suspended_out <= 1'b0;
        op_kind_out <= `KIND_NONE;
        done_out <= 1'b0;
    end else begin
        state_r <= state_nxt;
        kind_r <= kind_nxt;
        remain_r <= remain_nxt;
        lat_r <= lat_nxt;
        cmd_valid_out <= acc_nxt;
        cmd_reject_out <= rej_nxt;
        if (op_valid)
            cmd_byte_out <= op_byte;
        busy_out <= (state_nxt == ST_RUN) ||
                    (state_nxt == ST_SUSP_WAIT);
        suspended_out <= (state_nxt == ST_SUSP);
        op_kind_out <= kind_nxt;
        done_out <= done_nxt;
    end
end

endmodule
`default_nettype wire

// File: inc/suspend_map.vh
// Constants for the program/erase suspend controller
// Summary of operation
// - Program suspends in 7 us, then reads only; subsector erase in 15 us.
// - Sector and subsector erase suspend in 15 us; then all but excluded commands and a second suspend.
// - Erase suspended: refuse erases, status/config writes, OTP program.
// - Opcode 60h decodes as bulk erase, like the other bulk erase code.
`ifndef SUSPEND_MAP_VH
`define SUSPEND_MAP_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_MHZ 100
`define ERS_TO_SUSP_TYP_US 150
`define PGM_TO_SUSP_TYP_US 5
`define SSE_TO_SUSP_TYP_US 50
`define PGM_SUSP_TYP_US 7
`define PGM_SUSP_MAX_US 25
`define SSE_SUSP_TYP_US 15
`define SSE_SUSP_MAX_US 30
`define ERS_SUSP_TYP_US 15
`define ERS_SUSP_MAX_US 30
`define PGM_SUSP_CYC (`PGM_SUSP_TYP_US * `CLK_MHZ)
`define SSE_SUSP_CYC (`SSE_SUSP_TYP_US * `CLK_MHZ)
`define ERS_SUSP_CYC (`ERS_SUSP_TYP_US * `CLK_MHZ)

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_PROGRAM 8'h02
`define OP_SUBSECTOR_ERASE 8'h20
`define OP_SECTOR_ERASE 8'hd8
`define OP_BULK_ERASE_A 8'hc7
`define OP_BULK_ERASE_B 8'h60
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
`define OP_WRITE_STATUS 8'h01
`define OP_WRITE_NVCFG 8'hb1
`define OP_PROGRAM_OTP 8'h42
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_READ_STATUS 8'h05

// ----------------------------------------------------------------
// Operation kinds
// ----------------------------------------------------------------
`define KIND_NONE 3'h0
`define KIND_PGM 3'h1
`define KIND_SSE 3'h2
`define KIND_SE 3'h3
`define KIND_BE 3'h4

`endif

// File: src/cmd_shift_in.v
// Serial opcode receiver sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module cmd_shift_in (
    input wire mclk_in,
    input wire reset_in,
    input wire sclk_in,
    input wire cs_n_in,
    input wire mosi_in,
    output reg op_valid_out,
    output reg [7:0] op_byte_out
);

// ----------------------------------------------------------------
// Synchronisers
// ----------------------------------------------------------------
reg [2:0] meta_r;
reg [2:0] sync_r;
reg sclk_d_r;
reg [3:0] cnt_r;
reg [6:0] sh_r;
reg first_r;
wire sclk_rise;

assign sclk_rise = sync_r[2] & ~sclk_d_r;

always @(posedge mclk_in) begin
    if (reset_in) begin
        // Idle levels: clock low, select high, so no false edge
        meta_r <= 3'h2;
        sync_r <= 3'h2;
        sclk_d_r <= 1'b0;
    end else begin
        meta_r <= {sclk_in, cs_n_in, mosi_in};
        sync_r <= meta_r;
        sclk_d_r <= sync_r[2];
    end
end

// ----------------------------------------------------------------
// First byte of each frame is the opcode
// ----------------------------------------------------------------
always @(posedge mclk_in) begin
    if (reset_in) begin
        cnt_r <= 4'h0;
        sh_r <= 7'h00;
        first_r <= 1'b1;
        op_valid_out <= 1'b0;
        op_byte_out <= 8'h00;
    end else begin
        op_valid_out <= 1'b0;
        if (sync_r[1]) begin
            cnt_r <= 4'h0;
            first_r <= 1'b1;
        end else if (sclk_rise) begin
            sh_r <= {sh_r[5:0], sync_r[0]};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h7 && first_r) begin
                op_byte_out <= {sh_r, sync_r[0]};
                op_valid_out <= 1'b1;
                first_r <= 1'b0;
            end
        end
    end
end

endmodule
`default_nettype wire

// File: sim/spi_host_model.sv
// Serial host model that sends opcode frames to the controller
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output var logic sclk_out,
    output var logic cs_n_out,
    output var logic mosi_out
);
    // ------------------------------------------------------------
    // Host spacing before a suspend; the device never checks it
    // ------------------------------------------------------------
    localparam integer ERS_GAP_US = 150;
    localparam integer PGM_GAP_US = 5;
    localparam integer SSE_GAP_US = 50;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // One opcode, MSB first, clock still outside the frame
    task automatic send(input logic [7:0] op);
        integer i;
        cs_n_out <= 1'b0;
        for (i = 7; i >= 0; i--) begin
            mosi_out <= op[i];
            #62.5 sclk_out <= 1'b1;
            #62.5 sclk_out <= 1'b0;
        end
        #62.5 cs_n_out <= 1'b1;
        mosi_out <= ~op[0];
        #62.5;
    endtask
    task automatic hold_off(input integer us);
        #(us * 1000);
    endtask
endmodule
`default_nettype wire

// File: sim/suspend_props.sv
// Assertions on the ports of the suspend controller
`timescale 1ns/1ps
`default_nettype none
module suspend_props (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic cmd_valid_out,
    input wire logic [7:0] cmd_byte_out,
    input wire logic cmd_reject_out,
    input wire logic busy_out,
    input wire logic suspended_out,
    input wire logic [2:0] op_kind_out,
    input wire logic done_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    logic [12:0] wait_r;
    // Cycles spent waiting for a taken suspend to land
    always @(posedge mclk_in) begin
        if (reset_in || suspended_out || !busy_out) begin
            wait_r <= 13'h0;
        end else if (wait_r != 13'h0 ||
                     (cmd_valid_out && cmd_byte_out == 8'h75)) begin
            wait_r <= wait_r + 13'h1;
        end
    end
    AST_ONE_ANSWER: assert property (
        !(cmd_valid_out && cmd_reject_out))
        else $error("accept and refuse together");
    AST_PGM_LAT: assert property (
        op_kind_out == 3'h1 |-> wait_r <= 13'h9c4)
        else $error("program suspend too slow");
    AST_ERS_LAT: assert property (
        op_kind_out != 3'h1 |-> wait_r <= 13'hbb8)
        else $error("erase suspend too slow");
    AST_ERS_REJ: assert property (
        cmd_valid_out && suspended_out && op_kind_out != 3'h1 |->
        !(cmd_byte_out inside {8'h20, 8'hd8, 8'hc7, 8'h60, 8'h01, 8'hb1,
        8'h42})) else $error("excluded opcode taken");
    AST_PGM_READS: assert property (
        cmd_valid_out && suspended_out && op_kind_out == 3'h1 |->
        cmd_byte_out inside {8'h03, 8'h0b, 8'h05, 8'h7a})
        else $error("non-read taken in program suspend");
    AST_BULK_60: assert property (
        cmd_valid_out && cmd_byte_out == 8'h60 && !$past(busy_out) &&
        !$past(suspended_out) |-> busy_out && op_kind_out == 3'h4)
        else $error("60 did not start bulk erase");
    AST_KIND_HELD: assert property (
        suspended_out && $past(suspended_out) |-> $stable(op_kind_out))
        else $error("kind lost while suspended");
    AST_RESUME: assert property (
        cmd_valid_out && cmd_byte_out == 8'h7a && $past(suspended_out) |->
        ##[0:1] (busy_out && !suspended_out))
        else $error("resume did not restart");
    AST_STATE: assert property (!(busy_out && suspended_out))
        else $error("busy and suspended together");
    AST_DONE: assert property (
        done_out |-> ##[0:1] (!busy_out && op_kind_out == 3'h0))
        else $error("done without idle");
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the suspend controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk_in, reset_in, sclk_in, cs_n_in, mosi_in;
    logic cmd_valid_out, cmd_reject_out, busy_out, suspended_out, done_out;
    logic [7:0] cmd_byte_out;
    logic [2:0] op_kind_out;
    integer error_cnt = 0, total_checks = 0, n_ok = 0, n_rej = 0, cyc = 0;
    integer n_done = 0;
    logic [7:0] excl [7] = '{8'h20, 8'hd8, 8'hc7, 8'h60, 8'h01, 8'hb1,
        8'h42};
    spi_host_model host_u (.sclk_out(sclk_in), .cs_n_out(cs_n_in),
        .mosi_out(mosi_in));
    suspend_ctrl #(.PGM_CYC(3000), .SSE_CYC(8000), .SE_CYC(20000),
        .BE_CYC(600)) dut_u (.mclk_in, .reset_in, .sclk_in, .cs_n_in,
        .mosi_in, .cmd_valid_out, .cmd_byte_out, .cmd_reject_out,
        .busy_out, .suspended_out, .op_kind_out, .done_out);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Sends one opcode and expects exactly one answer pulse
    task automatic cmd(input logic [7:0] op, input logic ok);
        n_ok = 0;
        n_rej = 0;
        host_u.send(op);
        repeat (20) @(posedge mclk_in);
        check("answers", 8'(n_ok + n_rej), 8'h1);
        check("accepted", 8'(n_ok), {7'h0, ok});
        check("opcode", cmd_byte_out, op);
    endtask
    task automatic wait_for(input logic susp, input integer lim);
        integer k;
        for (k = 0; k < lim; k++) begin
            @(posedge mclk_in);
            if (susp ? suspended_out === 1'b1 : busy_out === 1'b0) break;
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_idle;
        cmd(8'h03, 1'b1);
        check("busy", {7'h0, busy_out}, 8'h0);
        $display("t_idle done");
    endtask
    task automatic t_bulk;
        logic [7:0] ops [2] = '{8'hc7, 8'h60};
        foreach (ops[i]) begin
            cmd(ops[i], 1'b1);
            check("kind", {5'h0, op_kind_out}, 8'h4);
            wait_for(1'b0, 700);
            check("busy", {7'h0, busy_out}, 8'h0);
        end
        @(posedge mclk_in);
        check("done pulses", 8'(n_done), 8'h2);
        $display("t_bulk done");
    endtask
    task automatic t_pgm;
        cmd(8'h02, 1'b1);
        cmd(8'h05, 1'b1);
        cmd(8'h03, 1'b0);
        cmd(8'h75, 1'b1);
        wait_for(1'b1, 2500);
        check("suspended", {7'h0, suspended_out}, 8'h1);
        check("kind", {5'h0, op_kind_out}, 8'h1);
        cmd(8'hd8, 1'b0);
        cmd(8'h0b, 1'b1);
        cmd(8'h7a, 1'b1);
        check("busy", {7'h0, busy_out}, 8'h1);
        host_u.hold_off(host_u.PGM_GAP_US);
        cmd(8'h75, 1'b1);
        wait_for(1'b1, 2500);
        check("suspended again", {7'h0, suspended_out}, 8'h1);
        cmd(8'h7a, 1'b1);
        wait_for(1'b0, 1400);
        check("finished", {7'h0, busy_out}, 8'h0);
        $display("t_pgm done");
    endtask
    task automatic t_erase(input logic [7:0] op, input logic [2:0] kind);
        cmd(op, 1'b1);
        if (kind == 3'h3)
            host_u.hold_off(host_u.ERS_GAP_US);
        else
            host_u.hold_off(host_u.SSE_GAP_US);
        cmd(8'h75, 1'b1);
        wait_for(1'b1, 3000);
        check("suspended", {7'h0, suspended_out}, 8'h1);
        foreach (excl[i]) cmd(excl[i], 1'b0);
        cmd(8'h05, 1'b1);
        cmd(8'h7a, 1'b1);
        check("kind", {5'h0, op_kind_out}, {5'h0, kind});
        wait_for(1'b0, 5000);
        check("finished", {7'h0, busy_out}, 8'h0);
        $display("t_erase done");
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cmd_valid_out === 1'b1) n_ok <= n_ok + 1;
        if (cmd_reject_out === 1'b1) n_rej <= n_rej + 1;
        if (done_out === 1'b1) n_done <= n_done + 1;
        if (cyc == 50000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        reset_in = 1'b1;
        repeat (16) @(posedge mclk_in);
        reset_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        t_idle();
        t_bulk();
        t_pgm();
        t_erase(8'hd8, 3'h3);
        t_erase(8'h20, 3'h2);
        summarize();
    end
endmodule
bind suspend_ctrl suspend_props props_u (.mclk_in, .reset_in,
    .cmd_valid_out, .cmd_byte_out, .cmd_reject_out, .busy_out,
    .suspended_out, .op_kind_out, .done_out);
`default_nettype wire
